/* File: core/fqm_freq_meter_map.vh */
// Contract
// RULE1: Count measured clock over reference-clock window
// RULE2: Result is a 24-bit read-only count
// RULE3: Reference source selected; runs only when enabled
// RULE4: Mode bit 31: 0 disabled, 1 enabled
// RULE5: Reference busy set on enable write until settled
// RULE6: Software disables, waits, reselects, enables, waits
// RULE7: Software selects source, enables, waits for ready
// RULE8: Software clears enable, then waits for ready
// RULE9: Measured source select; window length from mode
// RULE10: Start bit one starts; zero does nothing
// RULE11: Busy while measuring; result readable after
// RULE12: Done and ready interrupts gated by mask
// RULE13: Enable sets mask, disable clears, zeros ignored
// RULE14: Request held until pending bit cleared
// RULE15: Keeps measuring while processor in debug halt
// RULE16: Measures in sleep; wake needs bus clock
// RULE17: All registers reset zero except revision
// RULE18: Software disables meter before gating bus clock
// RULE19: Pending bit set on status one-to-zero fall
// RULE20: Status bit 0 busy, bit 1 reference busy
// RULE21: Clock inputs cross domains through two flops
// RULE22: Counter cleared at start; counts inside window
`ifndef FQM_FREQ_METER_MAP_VH
`define FQM_FREQ_METER_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FQM_OFS_CONTROL   12'h000
`define FQM_OFS_MODE      12'h004
`define FQM_OFS_STATUS    12'h008
`define FQM_OFS_RESULT    12'h00C
`define FQM_OFS_IRQ_EN    12'h010
`define FQM_OFS_IRQ_DIS   12'h014
`define FQM_OFS_IRQ_MASK  12'h018
`define FQM_OFS_IRQ_PEND  12'h01C
`define FQM_OFS_IRQ_CLR   12'h020
`define FQM_OFS_REVISION  12'h3FC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FQM_CTRL_START_BIT   0
`define FQM_MODE_REFEN_BIT   31
`define FQM_MODE_MSEL_HI     20
`define FQM_MODE_MSEL_LO     16
`define FQM_MODE_WIN_HI      15
`define FQM_MODE_WIN_LO      8
`define FQM_MODE_RSEL_HI     2
`define FQM_MODE_RSEL_LO     0
`define FQM_STAT_BUSY_BIT    0
`define FQM_STAT_RBUSY_BIT   1
`define FQM_IRQ_DONE_BIT     0
`define FQM_IRQ_RDY_BIT      1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FQM_RESET_WORD       32'h00000000
`define FQM_MODE_WMASK       32'h801FFF07
`define FQM_REVISION_VALUE   32'h00000100
`define FQM_REF_SETTLE_CYC   8'h04

`endif

/* File: core/fqm_freq_meter.v */
`timescale 1ns/100ps
`include "fqm_freq_meter_map.vh"

module fqm_freq_meter #(
  parameter                N_REF_SRC  = 8,
  parameter                N_MSR_SRC  = 32,
  parameter [31:0]         REVISION   = `FQM_REVISION_VALUE,  // Arbitrary value
  parameter [7:0]          REF_SETTLE = `FQM_REF_SETTLE_CYC
) (
  input  wire                 ref_clk,
  input  wire                 rstn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output reg                  pslverr,
  input  wire [N_REF_SRC-1:0] ref_src_clk,
  input  wire [N_MSR_SRC-1:0] measured_clock,
  output wire                 ref_clock_on,
  output wire                 irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function pick_ref;
    input [N_REF_SRC-1:0] v;
    input [2:0]           s;
    integer               i;
    begin
      pick_ref = 1'b0;
      for (i = 0; i < N_REF_SRC; i = i + 1) begin
        if (i == s) begin
          pick_ref = v[i];
        end
      end
    end
  endfunction

  function pick_msr;
    input [N_MSR_SRC-1:0] v;
    input [4:0]           s;
    integer               i;
    begin
      pick_msr = 1'b0;
      for (i = 0; i < N_MSR_SRC; i = i + 1) begin
        if (i == s) begin
          pick_msr = v[i];
        end
      end
    end
  endfunction

  function reg_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      reg_hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  localparam [1:0] RS_IDLE  = 2'h1;
  localparam [1:0] RS_WAIT  = 2'h2;
  localparam [1:0] MS_IDLE  = 2'h1;
  localparam [1:0] MS_COUNT = 2'h2;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg  [31:0] mode_config;
  reg  [1:0]  irq_mask_reg;
  reg  [1:0]  irq_pending_reg;
  reg  [1:0]  next_irq_mask;
  reg  [1:0]  next_irq_pending;
  reg         irq_out;
  reg  [31:0] next_prdata;
  reg  [23:0] measurement_result;
  reg  [7:0]  window_left;
  reg  [1:0]  meas_state;
  reg  [1:0]  ref_state;
  reg         ref_run;
  reg  [7:0]  settle_cnt;
  reg  [1:0]  status_prev;
  reg         ref_lvl;
  reg         ref_prev;
  reg         msr_lvl;
  reg         msr_prev;

  reg  [N_REF_SRC-1:0] ref_sync1;
  reg  [N_REF_SRC-1:0] ref_sync2;
  reg  [N_MSR_SRC-1:0] msr_sync1;
  reg  [N_MSR_SRC-1:0] msr_sync2;

  wire        acc_phase;
  wire        setup_phase;
  wire        wr_en;
  wire        hit_ctrl;
  wire        hit_mode;
  wire        hit_status;
  wire        hit_result;
  wire        hit_irq_en;
  wire        hit_irq_dis;
  wire        hit_irq_mask;
  wire        hit_irq_pend;
  wire        hit_irq_clr;
  wire        hit_revision;
  wire        mapped;
  wire        meas_busy;
  wire        ref_clock_busy;
  wire [2:0]  ref_source_select;
  wire [4:0]  measured_source_select;
  wire [7:0]  window_cycle_count;
  wire        ref_tap;
  wire        msr_tap;
  wire        ref_edge;
  wire        msr_edge;
  wire        start_wr;
  wire [1:0]  status_reg;
  wire [1:0]  status_fall;
  wire [1:0]  en_bits;
  wire [1:0]  dis_bits;
  wire [1:0]  clr_bits;

  assign ref_source_select      = mode_config[`FQM_MODE_RSEL_HI:`FQM_MODE_RSEL_LO];  // see RULE3
  assign measured_source_select = mode_config[`FQM_MODE_MSEL_HI:`FQM_MODE_MSEL_LO];  // see RULE9
  assign window_cycle_count     = mode_config[`FQM_MODE_WIN_HI:`FQM_MODE_WIN_LO];    // see RULE9

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign pready      = 1'b1;
  assign acc_phase   = psel & penable;
  assign setup_phase = psel & ~penable;
  assign wr_en       = acc_phase & pwrite;

  assign hit_ctrl     = reg_hit(paddr, `FQM_OFS_CONTROL);
  assign hit_mode     = reg_hit(paddr, `FQM_OFS_MODE);
  assign hit_status   = reg_hit(paddr, `FQM_OFS_STATUS);
  assign hit_result   = reg_hit(paddr, `FQM_OFS_RESULT);
  assign hit_irq_en   = reg_hit(paddr, `FQM_OFS_IRQ_EN);
  assign hit_irq_dis  = reg_hit(paddr, `FQM_OFS_IRQ_DIS);
  assign hit_irq_mask = reg_hit(paddr, `FQM_OFS_IRQ_MASK);
  assign hit_irq_pend = reg_hit(paddr, `FQM_OFS_IRQ_PEND);
  assign hit_irq_clr  = reg_hit(paddr, `FQM_OFS_IRQ_CLR);
  assign hit_revision = reg_hit(paddr, `FQM_OFS_REVISION);

  assign mapped = hit_ctrl | hit_mode | hit_status | hit_result | hit_irq_en |
                  hit_irq_dis | hit_irq_mask | hit_irq_pend | hit_irq_clr | hit_revision;

  assign start_wr = wr_en & hit_ctrl & pwdata[`FQM_CTRL_START_BIT];    // see RULE10
  assign en_bits  = (wr_en & hit_irq_en)  ? pwdata[1:0] : 2'h0;         // see RULE13
  assign dis_bits = (wr_en & hit_irq_dis) ? pwdata[1:0] : 2'h0;         // see RULE13
  assign clr_bits = (wr_en & hit_irq_clr) ? pwdata[1:0] : 2'h0;         // see RULE14

  // ----------------------------------------
  // Read data and error
  // ----------------------------------------
  always @* begin
    next_prdata = `FQM_RESET_WORD;
    if (pwrite) begin
      next_prdata = `FQM_RESET_WORD;
    end else if (hit_mode) begin
      next_prdata = mode_config;
    end else if (hit_status) begin
      next_prdata = {30'h0, status_reg};                                // see RULE20
    end else if (hit_result) begin
      next_prdata = {8'h00, measurement_result};                        // see RULE2
    end else if (hit_irq_mask) begin
      next_prdata = {30'h0, irq_mask_reg};
    end else if (hit_irq_pend) begin
      next_prdata = {30'h0, irq_pending_reg};
    end else if (hit_revision) begin
      next_prdata = REVISION;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= `FQM_RESET_WORD;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= next_prdata;
      pslverr <= ~mapped;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Mode register and reference enable
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_config <= `FQM_RESET_WORD;                                   // see RULE17
      ref_state   <= RS_IDLE;
      ref_run     <= 1'b0;
      settle_cnt  <= 8'h00;
    end else if (wr_en && hit_mode) begin
      mode_config <= pwdata & `FQM_MODE_WMASK;
      ref_state   <= RS_WAIT;                                           // see RULE5
      ref_run     <= 1'b0;
      settle_cnt  <= REF_SETTLE;
    end else begin
      case (ref_state)
        RS_IDLE: begin
          settle_cnt <= 8'h00;
        end
        RS_WAIT: begin
          if (settle_cnt == 8'h01 || settle_cnt == 8'h00) begin
            ref_state  <= RS_IDLE;                                      // see RULE5
            ref_run    <= mode_config[`FQM_MODE_REFEN_BIT];             // see RULE4
            settle_cnt <= 8'h00;
          end else begin
            settle_cnt <= settle_cnt - 8'h01;
          end
        end
        default: begin
          ref_state  <= RS_IDLE;
          ref_run    <= 1'b0;
          settle_cnt <= 8'h00;
        end
      endcase
    end
  end

  assign ref_clock_busy = (ref_state == RS_WAIT);                       // see RULE5
  assign ref_clock_on   = ref_run;                                      // see RULE3

  // ----------------------------------------
  // Clock sampling
  // ----------------------------------------
  // Two flops on every candidate pin before the selector reads it
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_sync1 <= {N_REF_SRC{1'b0}};
      ref_sync2 <= {N_REF_SRC{1'b0}};
      msr_sync1 <= {N_MSR_SRC{1'b0}};
      msr_sync2 <= {N_MSR_SRC{1'b0}};
    end else begin
      ref_sync1 <= ref_src_clk;                                         // see RULE21
      ref_sync2 <= ref_sync1;
      msr_sync1 <= measured_clock;                                      // see RULE21
      msr_sync2 <= msr_sync1;
    end
  end

  assign ref_tap = pick_ref(ref_sync2, ref_source_select) & ref_run;    // see RULE3
  assign msr_tap = pick_msr(msr_sync2, measured_source_select);         // see RULE9

  // ----------------------------------------
  // Edge detect
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_lvl  <= 1'b0;
      ref_prev <= 1'b0;
      msr_lvl  <= 1'b0;
      msr_prev <= 1'b0;
    end else begin
      ref_lvl  <= ref_tap;
      ref_prev <= ref_lvl;
      msr_lvl  <= msr_tap;
      msr_prev <= msr_lvl;
    end
  end

  assign ref_edge = ref_lvl & ~ref_prev;
  assign msr_edge = msr_lvl & ~msr_prev;

  // ----------------------------------------
  // Measurement engine
  // ----------------------------------------
  // Runs with no halt or sleep input.                                   see RULE15 see RULE16
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meas_state         <= MS_IDLE;
      window_left        <= 8'h00;
      measurement_result <= 24'h000000;
    end else if (start_wr) begin
      meas_state         <= (window_cycle_count != 8'h00) ? MS_COUNT : MS_IDLE; // see RULE11
      window_left        <= window_cycle_count;                         // see RULE9
      measurement_result <= 24'h000000;                                 // see RULE22
    end else begin
      case (meas_state)
        MS_IDLE: begin
          window_left <= 8'h00;
        end
        MS_COUNT: begin
          if (msr_edge) begin
            measurement_result <= measurement_result + 24'h000001;      // see RULE1
          end
          if (ref_edge) begin
            window_left <= window_left - 8'h01;
            if (window_left == 8'h01) begin
              meas_state <= MS_IDLE;                                    // see RULE11
            end
          end
        end
        default: begin
          meas_state <= MS_IDLE;
        end
      endcase
    end
  end

  assign meas_busy = (meas_state == MS_COUNT);                          // see RULE11

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign status_reg  = {ref_clock_busy, meas_busy};                     // see RULE20
  assign status_fall = status_prev & ~status_reg;                       // see RULE19

  // Pending set beats clear when both land in one cycle; for the mask, disable beats enable
  always @* begin
    next_irq_mask    = (irq_mask_reg | en_bits) & ~dis_bits;            // see RULE13
    next_irq_pending = (irq_pending_reg & ~clr_bits) | status_fall;     // see RULE14
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_prev     <= 2'h0;
      irq_mask_reg    <= 2'h0;
      irq_pending_reg <= 2'h0;
      irq_out         <= 1'b0;
    end else begin
      status_prev     <= status_reg;
      irq_mask_reg    <= next_irq_mask;
      irq_pending_reg <= next_irq_pending;
      irq_out         <= |(next_irq_pending & next_irq_mask);           // see RULE12
    end
  end

  assign irq = irq_out;

endmodule // fqm_freq_meter

/* File: dv/fqm_meter_monitor.sv */
`timescale 1ns/100ps
module fqm_meter_monitor #(
  parameter [31:0] REVISION = 32'h00000100
) (
  input wire        ref_clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        ref_clock_on,
  input wire        irq
);
  wire       wr = psel && penable && pwrite;
  wire       rd = psel && penable && !pwrite;
  reg  [3:0] since_mode;
  // ----
  // Cycles since last mode write
  // ----
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      since_mode <= 4'hF;
    else if (wr && paddr == 12'h004)
      since_mode <= 4'h0;
    else if (since_mode != 4'hF)
      since_mode <= since_mode + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ref_turn_on:
    assert property (wr && paddr == 12'h004 && pwdata[31] |-> ##[2:8] ref_clock_on)
    else $error("reference clock not enabled");
  a_ref_turn_off:
    assert property (wr && paddr == 12'h004 && !pwdata[31] |-> ##[2:8] !ref_clock_on)
    else $error("reference clock not disabled");
  a_ref_change_cause:
    assert property ($changed(ref_clock_on) |-> since_mode < 4'h8)
    else $error("reference clock changed without mode write");
  a_irq_hold:
    assert property (irq && !(wr && (paddr == 12'h020 || paddr == 12'h014)) |=> irq)
    else $error("interrupt dropped without clear");
  a_mask_off_quiet:
    assert property (wr && paddr == 12'h014 && pwdata[1:0] == 2'h3 |=> !irq)
    else $error("interrupt stays with mask cleared");
  a_reset_quiet:
    assert property ($rose(rstn) |-> !irq && !ref_clock_on)
    else $error("outputs not quiet after reset");
  a_result_width:
    assert property (rd && paddr == 12'h00C |-> prdata[31:24] == 8'h00)
    else $error("result wider than 24 bits");
  a_status_bits:
    assert property (rd && paddr == 12'h008 |-> prdata[31:2] == 30'h0)
    else $error("status reserved bits set");
  a_revision_read:
    assert property (rd && paddr == 12'h3FC |-> prdata == REVISION)
    else $error("revision mismatch");
endmodule // fqm_meter_monitor

bind fqm_freq_meter fqm_meter_monitor #(.REVISION(REVISION)) u_mon (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ref_clock_on(ref_clock_on), .irq(irq));

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`include "fqm_freq_meter_map.vh"
module testbench;
  reg         ref_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg  [7:0]  ref_src_clk = 8'h00;
  reg  [31:0] measured_clock = 32'h0;
  wire        ref_clock_on;
  wire        irq;
  reg  [2:0]  rdiv = 3'h0;
  reg         mdiv = 1'b0;
  reg  [31:0] rd;
  reg         err;
  integer     i;
  integer     bad_count = 0;
  integer     samples_checked = 0;

  always #10 ref_clk = ~ref_clk;
  // Reference source 0 at 200 ns, measured source 1 at 80 ns
  always @(posedge ref_clk) begin
    rdiv <= (rdiv == 3'h4) ? 3'h0 : rdiv + 3'h1;
    mdiv <= ~mdiv;
    if (rdiv == 3'h4) ref_src_clk[0] <= ~ref_src_clk[0];
    if (mdiv) measured_clock[1] <= ~measured_clock[1];
  end

  fqm_freq_meter i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_src_clk(ref_src_clk), .measured_clock(measured_clock),
    .ref_clock_on(ref_clock_on), .irq(irq));

  // ----
  // Bus tasks
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task xfer(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (n < 16) begin
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
      end else begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
    end
  endtask

  task wait_clear(input integer b);
    integer k;
    begin
      k = 0;
      do begin
        xfer(1'b0, 12'h008, 32'h0);
        k = k + 1;
      end while (rd[b] !== 1'b0 && k < 64);
      if (k >= 64) begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // ----
  // Tests
  // ----
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 1; i < 8; i = i + 1) begin
      if (i != 4 && i != 5) begin
        xfer(1'b0, 12'(i * 4), 32'h0);
        chk(rd, 32'h0);
      end
    end
    xfer(1'b0, 12'h3FC, 32'h0);
    chk(rd, `FQM_REVISION_VALUE);
    xfer(1'b0, 12'h100, 32'h0);
    chk(err, 32'h1);
    $display("reset test done");
    xfer(1'b1, 12'h004, 32'h00010800);
    wait_clear(1);
    xfer(1'b1, 12'h004, 32'h80010800);
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h2);
    wait_clear(1);
    chk(ref_clock_on, 32'h1);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h80010800);
    xfer(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h2);
    xfer(1'b1, 12'h010, 32'h3);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 32'h1);
    xfer(1'b1, 12'h020, 32'h2);
    chk(irq, 32'h0);
    xfer(1'b1, 12'h014, 32'h1);
    xfer(1'b1, 12'h010, 32'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h2);
    $display("reference and mask test done");
    xfer(1'b1, 12'h000, 32'h0);
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 12'h000, 32'h1);
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1);
    wait_clear(0);
    xfer(1'b0, 12'h00C, 32'h0);
    chk(rd >= 32'h11 && rd <= 32'h15, 32'h1);
    xfer(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 32'h0);
    xfer(1'b1, 12'h010, 32'h1);
    chk(irq, 32'h1);
    xfer(1'b1, 12'h020, 32'h3);
    chk(irq, 32'h0);
    $display("measurement test done");
    xfer(1'b1, 12'h004, 32'h00010800);
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h2);
    wait_clear(1);
    chk(ref_clock_on, 32'h0);
    xfer(1'b1, 12'h004, 32'h00010801);
    wait_clear(1);
    xfer(1'b1, 12'h004, 32'h80010801);
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h2);
    wait_clear(1);
    chk(ref_clock_on, 32'h1);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h80010801);
    xfer(1'b1, 12'h004, 32'h00010801);
    wait_clear(1);
    chk(ref_clock_on, 32'h0);
    xfer(1'b1, 12'h014, 32'h3);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    $display("disable test done");
    tally_and_finish;
  end
endmodule // testbench
